// file: src/lcu_link_control.sv
/*
 * Upper fields (bits 15:6) of a switch port link control register, its two
 * bandwidth status flags, and a sticky/mask interrupt pair, behind classic Wishbone.
 * Assumes the link training logic supplies one-cycle event pulses and static
 * port configuration (upstream flag, bandwidth notification capability).
 */
// Functional notes
// R1: Bit 6 read-write common reference clock flag, reset zero, drives output.
// R2: Bit 7 read-write extended sync enable, reset zero, drives transmitter.
// R3: Bit 8 clock power management is read-only zero; writes ignored.
// R4: Bit 9 autonomous width disable is read-only zero.
// R5: Bit 10 enables interrupt when bandwidth management status flag sets.
// R6: Bit 11 enables interrupt when autonomous bandwidth status flag sets.
// R7: Both enables read zero when bandwidth notification capability is clear.
// R8: Both enables read zero in the upstream port, writes ignored.
// R9: Bandwidth status set on retrain completion or reliability change without link down.
// R10: Bits 15 to 12 of link control read zero, writes ignored.
`timescale 1ns/1ps
module lcu_link_control
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic upstream_port_i,
    input wire logic bw_notify_capable_i,
    input wire logic retrain_done_i,
    input wire logic reliability_change_i,
    input wire logic autonomous_change_i,
    input wire logic dl_down_i,
    output logic common_refclk_flag_o,
    output logic extended_sync_enable_o,
    output logic bw_mgmt_irq_enable_o,
    output logic autonomous_bw_irq_enable_o,
    output logic bw_mgmt_irq_o,
    output logic irq_o
);
    import lcu_pkg::*;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic req;
    logic wr;
    logic irq_allowed;
    logic ccfg_q;
    logic extended_sync_enable_q;
    logic bwm_en_q;
    logic abw_en_q;
    logic bwm_sts_q;
    logic abw_sts_q;
    logic [1:0] irq_sts_q;
    logic [1:0] irq_mask_q;
    logic [1:0] irq_evt;
    logic bwm_set;
    logic abw_set;
    logic [31:0] rd_d;
    logic ctrl_lo_we;
    logic ctrl_hi_we;
    logic lsts_hi_we;
    logic irq_sts_we;
    logic irq_mask_we;
    logic bwm_clr;
    logic abw_clr;
    logic bwm_en_eff;
    logic abw_en_eff;
    logic [15:0] ctrl_word;
    logic [15:0] lsts_word;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i;
    // Enables are only meaningful on a notification-capable downstream port
    assign irq_allowed = bw_notify_capable_i && !upstream_port_i; // [R7] [R8]

    function automatic logic wr_hit(input logic [3:0] adr, input logic [3:0] a,
                                    input logic [3:0] sel, input int lane);
        wr_hit = (adr == a) && sel[lane];
    endfunction

    // Effective enable: a stored one only counts while the port may interrupt
    function automatic logic gate_en(input logic en, input logic allowed);
        gate_en = en && allowed;
    endfunction

    // Fixed-zero fields are never stored, so no write can ever reach them
    function automatic logic [15:0] pack_ctrl(input logic cc, input logic es,
                                              input logic bwm, input logic abw);
        pack_ctrl = 16'h0000; // [R10]
        pack_ctrl[LCU_BIT_COMMON_REFCLK] = cc;
        pack_ctrl[LCU_BIT_EXT_SYNC] = es;
        pack_ctrl[LCU_BIT_CLK_PM] = 1'h0; // [R3]
        pack_ctrl[LCU_BIT_AUTO_WIDTH_DIS] = 1'h0; // [R4]
        pack_ctrl[LCU_BIT_BW_MGMT_IRQ_EN] = bwm;
        pack_ctrl[LCU_BIT_AUTO_BW_IRQ_EN] = abw;
    endfunction

    function automatic logic [15:0] pack_lsts(input logic bwm, input logic abw);
        pack_lsts = 16'h0000;
        pack_lsts[LCU_BIT_BW_MGMT_STS] = bwm;
        pack_lsts[LCU_BIT_AUTO_BW_STS] = abw;
    endfunction

    // ----------------------------------------
    // Write strobes
    // ----------------------------------------
    // One strobe per register lane, so each field's write condition reads in one place
    assign ctrl_lo_we = wr && wr_hit(wb_adr_i, LCU_ADDR_LINK_CONTROL, wb_sel_i, 0);
    assign ctrl_hi_we = wr && wr_hit(wb_adr_i, LCU_ADDR_LINK_CONTROL, wb_sel_i, 1);
    assign lsts_hi_we = wr && wr_hit(wb_adr_i, LCU_ADDR_LINK_STATUS, wb_sel_i, 1);
    assign irq_sts_we = wr && wr_hit(wb_adr_i, LCU_ADDR_IRQ_STATUS, wb_sel_i, 0);
    assign irq_mask_we = wr && wr_hit(wb_adr_i, LCU_ADDR_IRQ_MASK, wb_sel_i, 0);
    assign bwm_clr = lsts_hi_we && wb_dat_i[LCU_BIT_BW_MGMT_STS];
    assign abw_clr = lsts_hi_we && wb_dat_i[LCU_BIT_AUTO_BW_STS];

    // ----------------------------------------
    // Effective enables and read words
    // ----------------------------------------
    assign bwm_en_eff = gate_en(bwm_en_q, irq_allowed); // [R7] [R8]
    assign abw_en_eff = gate_en(abw_en_q, irq_allowed); // [R7] [R8]
    assign ctrl_word = pack_ctrl(ccfg_q, extended_sync_enable_q, bwm_en_eff, abw_en_eff);
    assign lsts_word = pack_lsts(bwm_sts_q, abw_sts_q);

    // ----------------------------------------
    // Link control fields
    // ----------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ccfg_q <= LCU_RST_FLAG;
        end
        else if (ctrl_lo_we)
        begin
            ccfg_q <= wb_dat_i[LCU_BIT_COMMON_REFCLK]; // [R1]
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            extended_sync_enable_q <= LCU_RST_FLAG;
        end
        else if (ctrl_lo_we)
        begin
            extended_sync_enable_q <= wb_dat_i[LCU_BIT_EXT_SYNC]; // [R2]
        end
    end

    // Cleared while not allowed, so a later capability change exposes no stale one
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !irq_allowed)
        begin
            bwm_en_q <= LCU_RST_FLAG; // [R7] [R8]
        end
        else if (ctrl_hi_we)
        begin
            bwm_en_q <= wb_dat_i[LCU_BIT_BW_MGMT_IRQ_EN]; // [R5]
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !irq_allowed)
        begin
            abw_en_q <= LCU_RST_FLAG; // [R7] [R8]
        end
        else if (ctrl_hi_we)
        begin
            abw_en_q <= wb_dat_i[LCU_BIT_AUTO_BW_IRQ_EN]; // [R6]
        end
    end

    // ----------------------------------------
    // Bandwidth status flags
    // ----------------------------------------
    // A link-down in the same cycle suppresses the event: no link-down passage allowed
    assign bwm_set = irq_allowed && !dl_down_i && (retrain_done_i || reliability_change_i); // [R9]
    assign abw_set = irq_allowed && !dl_down_i && autonomous_change_i;

    // Set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bwm_sts_q <= LCU_RST_FLAG;
        end
        else if (bwm_set)
        begin
            bwm_sts_q <= 1'h1; // [R9]
        end
        else if (bwm_clr)
        begin
            bwm_sts_q <= 1'h0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            abw_sts_q <= LCU_RST_FLAG;
        end
        else if (abw_set)
        begin
            abw_sts_q <= 1'h1;
        end
        else if (abw_clr)
        begin
            abw_sts_q <= 1'h0;
        end
    end

    // ----------------------------------------
    // Interrupt status and mask
    // ----------------------------------------
    // Events fire only when the matching enable is set
    assign irq_evt[LCU_IRQ_BW_MGMT] = bwm_set && bwm_en_q; // [R5]
    assign irq_evt[LCU_IRQ_AUTO_BW] = abw_set && abw_en_q; // [R6]

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_sts_q <= LCU_RST_IRQ;
        end
        else if (irq_sts_we)
        begin
            irq_sts_q <= (irq_sts_q & ~wb_dat_i[1:0]) | irq_evt;
        end
        else
        begin
            irq_sts_q <= irq_sts_q | irq_evt;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_mask_q <= LCU_RST_IRQ;
        end
        else if (irq_mask_we)
        begin
            irq_mask_q <= wb_dat_i[1:0];
        end
    end

    // Registered so the pin never glitches while status and mask settle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_o <= 1'h0;
        end
        else
        begin
            irq_o <= |(irq_sts_q & irq_mask_q);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bw_mgmt_irq_o <= 1'h0;
        end
        else
        begin
            bw_mgmt_irq_o <= irq_sts_q[LCU_IRQ_BW_MGMT] & irq_mask_q[LCU_IRQ_BW_MGMT];
        end
    end

    // ----------------------------------------
    // Read mux and acknowledge
    // ----------------------------------------
    always_comb
    begin
        rd_d = 32'h0;
        case (wb_adr_i)
            LCU_ADDR_LINK_CONTROL: rd_d[15:0] = ctrl_word; // [R3] [R4] [R10]
            LCU_ADDR_LINK_STATUS: rd_d[15:0] = lsts_word;
            LCU_ADDR_IRQ_STATUS: rd_d[1:0] = irq_sts_q;
            LCU_ADDR_IRQ_MASK: rd_d[1:0] = irq_mask_q;
            default: rd_d = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'h0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rd_d : 32'h0;
        end
    end

    // ----------------------------------------
    // Field outputs
    // ----------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            common_refclk_flag_o <= 1'h0;
        end
        else
        begin
            common_refclk_flag_o <= ccfg_q; // [R1]
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            extended_sync_enable_o <= 1'h0;
        end
        else
        begin
            extended_sync_enable_o <= extended_sync_enable_q; // [R2]
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bw_mgmt_irq_enable_o <= 1'h0;
        end
        else
        begin
            bw_mgmt_irq_enable_o <= bwm_en_eff; // [R5]
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            autonomous_bw_irq_enable_o <= 1'h0;
        end
        else
        begin
            autonomous_bw_irq_enable_o <= abw_en_eff; // [R6]
        end
    end
endmodule

// file: src/lcu_pkg.sv
/*
 * Package for the link control upper-field block: register offsets, field positions,
 * reset values and interrupt bit layout.
 * Assumes a 32-bit classic Wishbone slave with word-aligned registers.
 */
package lcu_pkg;
    localparam logic [3:0] LCU_ADDR_LINK_CONTROL = 4'h0;
    localparam logic [3:0] LCU_ADDR_LINK_STATUS = 4'h4;
    localparam logic [3:0] LCU_ADDR_IRQ_STATUS = 4'h8;
    localparam logic [3:0] LCU_ADDR_IRQ_MASK = 4'hC;
    localparam int LCU_BIT_COMMON_REFCLK = 6;
    localparam int LCU_BIT_EXT_SYNC = 7;
    localparam int LCU_BIT_CLK_PM = 8;
    localparam int LCU_BIT_AUTO_WIDTH_DIS = 9;
    localparam int LCU_BIT_BW_MGMT_IRQ_EN = 10;
    localparam int LCU_BIT_AUTO_BW_IRQ_EN = 11;
    localparam int LCU_BIT_BW_MGMT_STS = 14;
    localparam int LCU_BIT_AUTO_BW_STS = 15;
    localparam int LCU_IRQ_BW_MGMT = 0;
    localparam int LCU_IRQ_AUTO_BW = 1;
    localparam logic LCU_RST_FLAG = 1'h0;
    localparam logic [1:0] LCU_RST_IRQ = 2'h0;
endpackage

// file: verification/lcu_sva.sv
/*
 * Port checker for lcu_link_control.
 * Assumes a classic single-cycle Wishbone master and sync active-high reset.
 */
`timescale 1ns/1ps
module lcu_sva
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic upstream_port_i,
    input wire logic bw_notify_capable_i,
    input wire logic common_refclk_flag_o,
    input wire logic bw_mgmt_irq_enable_o,
    input wire logic autonomous_bw_irq_enable_o,
    input wire logic bw_mgmt_irq_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack late");
    property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_pulse: assert property (p_pulse) else $error("ack too long");
    property p_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside ack");
    property p_rsvd; wb_ack_o && !wb_we_i && wb_adr_i == 4'h0 |-> wb_dat_o[15:12] == 4'h0
        && wb_dat_o[9:8] == 2'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("fixed zero bit set");
    property p_up; upstream_port_i [*3] |-> !bw_mgmt_irq_enable_o; endproperty
    a_up: assert property (p_up) else $error("enable on upstream");
    property p_cap; !bw_notify_capable_i [*3] |-> !autonomous_bw_irq_enable_o; endproperty
    a_cap: assert property (p_cap) else $error("enable without capability");
    property p_or; bw_mgmt_irq_o |-> irq_o; endproperty
    a_or: assert property (p_or) else $error("irq output low");
    property p_ref; wb_ack_o && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[0]
        |-> ##2 common_refclk_flag_o == $past(wb_dat_i[6], 2); endproperty
    a_ref: assert property (p_ref) else $error("refclk flag wrong");
    c_wr: cover property (wb_ack_o && wb_we_i);
    c_irq: cover property (irq_o);
    c_up: cover property (upstream_port_i [*3]);
endmodule
bind lcu_link_control lcu_sva chk_u (.*);

// file: verification/testbench.sv
/*
 * Self-checking bench for lcu_link_control.
 * Assumes the checker is bound separately.
 */
`timescale 1ns/1ps
module testbench;
    import lcu_pkg::*;
    // Compare and count
    `define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
        $display("wrong value at %0t: %h not %h", $time, a, b); end end
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r;
    logic wb_ack_o, upstream_port_i = 0, bw_notify_capable_i = 1, retrain_done_i = 0;
    logic reliability_change_i = 0, autonomous_change_i = 0, dl_down_i = 0;
    logic common_refclk_flag_o, extended_sync_enable_o, bw_mgmt_irq_enable_o;
    logic autonomous_bw_irq_enable_o, bw_mgmt_irq_o, irq_o;
    logic [15:0] d;
    int fail_count = 0, samples_checked = 0, cyc_n = 0, seed = 16096;
    lcu_link_control dut_u (.*);
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cyc_n++;
        if (cyc_n == 20000)
        begin
            fail_count++;
            end_sim();
        end
    end
    task end_sim;
        $display("checked %0d, wrong %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Holds the request until ack is seen, then idles one cycle
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
        int n;
        n = 0;
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= v;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n == 20)
        begin
            fail_count++;
            end_sim();
        end
        r = wb_dat_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
        @(posedge clk_i);
    endtask
    function automatic logic [15:0] exp_ctrl(input logic [15:0] v, input logic up, input logic c);
        return (up || !c) ? v & 16'h00C0 : v & 16'h0CC0;
    endfunction
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        bus(0, LCU_ADDR_LINK_CONTROL, 0);
        `CHK(r, 32'h0)
        for (int i = 0; i < 12; i++)
        begin
            d = (i == 0) ? 16'hFFFF : 16'($random(seed));
            upstream_port_i <= (i % 4 == 1);
            bw_notify_capable_i <= (i % 4 != 2);
            @(posedge clk_i);
            bus(1, LCU_ADDR_LINK_CONTROL, {16'h0, d});
            bus(0, LCU_ADDR_LINK_CONTROL, 0);
            `CHK(r[15:0], exp_ctrl(d, i % 4 == 1, i % 4 != 2))
            `CHK(common_refclk_flag_o, d[6])
            `CHK(extended_sync_enable_o, d[7])
            `CHK(autonomous_bw_irq_enable_o, exp_ctrl(d, i % 4 == 1, i % 4 != 2) >> 11 & 1)
            `CHK(bw_mgmt_irq_enable_o, exp_ctrl(d, i % 4 == 1, i % 4 != 2) >> 10 & 1)
        end
        $display("control test done");
        upstream_port_i <= 0;
        bw_notify_capable_i <= 1;
        bus(1, LCU_ADDR_LINK_CONTROL, 32'h0C00);
        bus(1, LCU_ADDR_IRQ_MASK, 32'h3);
        for (int k = 0; k < 4; k++)
        begin
            retrain_done_i <= (k == 0 || k == 3);
            reliability_change_i <= (k == 1);
            autonomous_change_i <= (k == 2);
            dl_down_i <= (k == 3);
            @(posedge clk_i);
            {retrain_done_i, reliability_change_i, autonomous_change_i, dl_down_i} <= 4'h0;
            repeat (2) @(posedge clk_i);
            `CHK(irq_o, k != 3)
            `CHK(bw_mgmt_irq_o, k < 2)
            bus(0, LCU_ADDR_LINK_STATUS, 0);
            `CHK(r[15:14], k == 2 ? 2'h2 : (k == 3 ? 2'h0 : 2'h1))
            bus(1, LCU_ADDR_LINK_STATUS, 32'hC000);
            bus(1, LCU_ADDR_IRQ_STATUS, 32'h3);
            @(posedge clk_i);
            `CHK(irq_o, 1'b0)
        end
        bus(1, 4'h2, 32'hFFFFFFFF);
        bus(0, 4'h2, 0);
        `CHK(r, 32'h0)
        $display("event test done");
        end_sim();
    end
endmodule
